// ==== pkg/irs_pkg.sv ====
// constants and types for the internal reset sequencer
package irs_pkg;
  // register byte offsets
  localparam logic [7:0] RESET_SOURCE_OFF  = 8'h00;
  localparam logic [7:0] CPU_CLK_STAT_OFF  = 8'h04;
  localparam logic [7:0] LV_MODE_OFF       = 8'h08;
  localparam logic [7:0] DEBUG_MODE_OFF    = 8'h0c;
  localparam logic [7:0] WD_CTRL_OFF       = 8'h10;
  localparam logic [7:0] SEQ_STAT_OFF      = 8'h14;
  // reset_source_reg fields
  localparam int LV_FLAG_BIT = 0;
  localparam int CM_FLAG_BIT = 1;
  localparam int WD_FLAG_BIT = 4;
  localparam logic [7:0] RESET_SOURCE_MASK = 8'h13;
  // low_voltage_mode_reg fields
  localparam int LV_EN_BIT  = 0;
  localparam int LV_SEL_BIT = 1;
  // debug_mode_control_reg value set by a pin reset
  localparam logic [7:0] DEBUG_MODE_RST = 8'h01;
  // cpu divider initial select: fxx/8
  localparam logic [2:0] CPU_DIV_RST = 3'h3;
  // timing
  localparam int  CLK_MHZ           = 200;
  localparam int  WD_HOLD_NS        = 1000;
  localparam int  WD_HOLD_CYC       = (WD_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int  OSC_STAB_SHORT    = 8192;
  localparam int  OSC_STAB_LONG     = 65536;
  localparam int  WD_OVF_DEFAULT    = 16384;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    IRS_IN_RESET,
    IRS_STABILIZE,
    IRS_RUN_MAIN,
    IRS_RUN_EMERG
  } irs_state_e;
endpackage : irs_pkg

// ==== verilog/irs_cnt.sv ====
// resettable up-counter with terminal flag, used for hold and stabilisation timing
`timescale 1ns/1ps
`default_nettype none
module irs_cnt #(
  parameter int W = 20
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         clr_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] limit_i,
  output logic [W-1:0]      count_o,
  output logic              done_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (clr_i)
      cnt_d = '0;
    else if (en_i && (cnt_q != limit_i))
      cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign count_o = cnt_q;
  assign done_o  = (cnt_q == limit_i);
endmodule : irs_cnt
`default_nettype wire

// ==== verilog/irs_sequencer.sv ====
// internal reset sequencer with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - watchdog overflow in reset mode raises a full system reset
// - watchdog reset holds a fixed time then releases by itself
// - main oscillator stopped while watchdog or low-voltage reset is active
// - cpu clock stopped in reset; restarts after stabilisation at divide by eight
// - peripheral clocks stopped in reset; resume after stabilisation
// - watchdog counter cleared in reset; counts from zero on internal oscillator after
// - peripheral registers reset; debug-mode register keeps value on internal resets
// - ram kept on watchdog reset; power-on, collision or low-voltage reset corrupts it
// - enabled detector with select bit 1 causes system reset on drop
// - low-voltage reset held until supply returns above level
// - select bit 0 gives interrupt on crossings both ways instead
// - after reset oscillator starts; option-selected stabilisation counted before fetch
// - watchdog overflow before stabilisation starts cpu on internal oscillator
// - readable status tells main clock or internal oscillator for cpu
// - pin reset clears flags; other sources set only own flag
// - software writes only clear flags; hardware set wins
// - pin reset clears whole reset-source register
module irs_sequencer
  import irs_pkg::*;
#(
  parameter int WD_HOLD    = irs_pkg::WD_HOLD_CYC,
  parameter int STAB_SHORT = irs_pkg::OSC_STAB_SHORT,
  parameter int STAB_LONG  = irs_pkg::OSC_STAB_LONG,
  parameter int WD_OVF     = irs_pkg::WD_OVF_DEFAULT
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        pin_reset_n_i,
  input  wire logic        lv_below_i,
  input  wire logic        cm_reset_req_i,
  input  wire logic        stab_long_sel_i,
  input  wire logic        main_clk_ok_i,
  input  wire logic        cpu_ram_access_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             sys_reset_o,
  output logic             main_osc_en_o,
  output logic             int_osc_en_o,
  output logic             cpu_clk_en_o,
  output logic             periph_clk_en_o,
  output logic [2:0]       cpu_div_sel_o,
  output logic             cpu_on_int_osc_o,
  output logic             low_voltage_irq_o,
  output logic             ram_corrupt_o
);
  import irs_pkg::*;

  // pins from outside pass two flops; first stage feeds only the second
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sync1_q <= 3'h1;
      sync2_q <= 3'h1;
    end
    else
    begin
      sync1_q <= {lv_below_i, main_clk_ok_i, pin_reset_n_i};
      sync2_q <= sync1_q;
    end
  end
  logic pin_rst;
  logic lv_below;
  logic main_ok;
  assign pin_rst  = !sync2_q[0];
  assign main_ok  = sync2_q[1];
  assign lv_below = sync2_q[2];

  // registers and sequencer state
  irs_state_e st_q, st_d;
  logic [7:0]  rsrc_q, rsrc_d;
  logic [1:0]  lvmode_q, lvmode_d;
  logic [7:0]  dbg_q, dbg_d;
  logic        wd_rst_en_q, wd_rst_en_d;
  logic        lv_prev_q, lv_prev_d;
  logic        irq_q, irq_d;
  logic        wd_hold_q, wd_hold_d;
  logic        lv_hold_q, lv_hold_d;
  logic [19:0] wd_cnt_q, wd_cnt_d;
  logic        ramc_q, ramc_d;

  logic        wd_ovf_ev;
  logic        lv_rst_req;
  logic        any_rst;
  logic        in_reset;
  logic        hold_done;
  logic        stab_done;
  logic [19:0] stab_lim;
  logic        sw_rsrc_wr;
  logic [7:0]  sw_rsrc_val;
  logic        sw_lv_wr;
  logic        sw_dbg_wr;
  logic        sw_wd_wr;
  logic        sw_wd_clr;

  assign in_reset   = (st_q == IRS_IN_RESET);
  // overflow while stabilising is the emergency fall-back, never a reset loop
  assign wd_ovf_ev  = ((st_q == IRS_RUN_MAIN) || (st_q == IRS_RUN_EMERG)) && wd_rst_en_q
                      && (wd_cnt_q == 20'(WD_OVF - 1));
  assign lv_rst_req = lvmode_q[LV_EN_BIT] && lvmode_q[LV_SEL_BIT] && lv_below;
  assign any_rst    = pin_rst || wd_ovf_ev || cm_reset_req_i || lv_rst_req;
  assign stab_lim   = stab_long_sel_i ? 20'(STAB_LONG) : 20'(STAB_SHORT);

  irs_cnt #(.W(20)) u_hold (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clr_i   (!in_reset || wd_ovf_ev),
    .en_i    (wd_hold_q),
    .limit_i (20'(WD_HOLD)),
    .count_o (),
    .done_o  (hold_done)
  );

  irs_cnt #(.W(20)) u_stab (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clr_i   (st_q != IRS_STABILIZE),
    .en_i    (main_ok),
    .limit_i (stab_lim),
    .count_o (),
    .done_o  (stab_done)
  );

  // sequencer
  always_comb
  begin
    st_d      = st_q;
    wd_hold_d = wd_hold_q;
    // the mode register is cleared on entry, so a low-voltage reset is remembered here
    lv_hold_d = (lv_rst_req || lv_hold_q) && lv_below;
    unique case (st_q)
      IRS_IN_RESET:
      begin
        // release waits until no level request is still present and any watchdog hold has run out
        if (!pin_rst && !lv_rst_req && !lv_hold_q && !cm_reset_req_i
            && (!wd_hold_q || hold_done))
        begin
          st_d      = IRS_STABILIZE;
          wd_hold_d = 1'b0;
        end
      end
      IRS_STABILIZE:
      begin
        if (wd_cnt_q == 20'(WD_OVF - 1))
          st_d = IRS_RUN_EMERG;
        else if (stab_done)
          st_d = IRS_RUN_MAIN;
      end
      IRS_RUN_MAIN:  st_d = IRS_RUN_MAIN;
      IRS_RUN_EMERG: st_d = IRS_RUN_EMERG;
    endcase
    if (any_rst)
    begin
      st_d = IRS_IN_RESET;
      if (wd_ovf_ev)
        wd_hold_d = 1'b1;
    end
  end

  // watchdog counter, interrupt, flags, config registers
  always_comb
  begin
    wd_cnt_d    = wd_cnt_q;
    rsrc_d      = rsrc_q;
    lvmode_d    = lvmode_q;
    dbg_d       = dbg_q;
    wd_rst_en_d = wd_rst_en_q;
    lv_prev_d   = lv_below;
    irq_d       = 1'b0;
    ramc_d      = ramc_q;
    // the watchdog restarts from zero once the cpu falls back to the internal oscillator
    if (in_reset || sw_wd_clr || (st_d == IRS_IN_RESET) || ((st_q == IRS_STABILIZE) && (st_d == IRS_RUN_EMERG)))
      wd_cnt_d = '0;
    else if (wd_cnt_q != 20'(WD_OVF - 1))
      wd_cnt_d = wd_cnt_q + 20'h00001;
    if (lvmode_q[LV_EN_BIT] && !lvmode_q[LV_SEL_BIT] && (lv_below != lv_prev_q))
      irq_d = 1'b1;
    if (sw_lv_wr)
      lvmode_d = sw_rsrc_val[1:0];
    if (sw_dbg_wr)
      dbg_d = sw_rsrc_val;
    if (sw_wd_wr)
      wd_rst_en_d = sw_rsrc_val[0];
    if (sw_rsrc_wr)
      rsrc_d = rsrc_q & sw_rsrc_val & RESET_SOURCE_MASK;
    if (wd_ovf_ev)
      rsrc_d[WD_FLAG_BIT] = 1'b1;
    if (cm_reset_req_i)
      rsrc_d[CM_FLAG_BIT] = 1'b1;
    if (lv_rst_req)
      rsrc_d[LV_FLAG_BIT] = 1'b1;
    if (any_rst && !in_reset)
    begin
      lvmode_d    = 2'h0;
      wd_rst_en_d = 1'b1;
      // ram is kept unless the cpu was mid-access; a supply drop always loses it
      ramc_d      = cpu_ram_access_i || lv_rst_req;
    end
    if (pin_rst)
    begin
      rsrc_d = 8'h00;
      dbg_d  = DEBUG_MODE_RST;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_q        <= IRS_IN_RESET;
      wd_hold_q   <= 1'b0;
      lv_hold_q   <= 1'b0;
      wd_cnt_q    <= '0;
      rsrc_q      <= 8'h00;
      lvmode_q    <= 2'h0;
      dbg_q       <= DEBUG_MODE_RST;
      wd_rst_en_q <= 1'b1;
      lv_prev_q   <= 1'b0;
      irq_q       <= 1'b0;
      ramc_q      <= 1'b1;
    end
    else
    begin
      st_q        <= st_d;
      wd_hold_q   <= wd_hold_d;
      lv_hold_q   <= lv_hold_d;
      wd_cnt_q    <= wd_cnt_d;
      rsrc_q      <= rsrc_d;
      lvmode_q    <= lvmode_d;
      dbg_q       <= dbg_d;
      wd_rst_en_q <= wd_rst_en_d;
      lv_prev_q   <= lv_prev_d;
      irq_q       <= irq_d;
      ramc_q      <= ramc_d;
    end
  end

  // clock gating outputs, all registered; the cpu divider select is the constant CPU_DIV_RST
  logic [7:0] out_q, out_d;
  always_comb
  begin
    out_d    = 8'h00;
    out_d[0] = (st_d == IRS_IN_RESET);
    out_d[1] = (st_d != IRS_IN_RESET);
    out_d[2] = (st_d != IRS_IN_RESET);
    out_d[3] = (st_d == IRS_RUN_MAIN) || (st_d == IRS_RUN_EMERG);
    out_d[4] = (st_d == IRS_RUN_MAIN);
    out_d[5] = (st_d == IRS_RUN_EMERG);
  end
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      out_q <= 8'h01;
    else
      out_q <= out_d;
  end
  assign sys_reset_o       = out_q[0];
  assign main_osc_en_o     = out_q[1];
  assign int_osc_en_o      = out_q[2];
  assign cpu_clk_en_o      = out_q[3];
  assign periph_clk_en_o   = out_q[4];
  assign cpu_on_int_osc_o  = out_q[5];
  assign cpu_div_sel_o     = CPU_DIV_RST;
  assign low_voltage_irq_o = irq_q;
  assign ram_corrupt_o     = ramc_q;

  // AXI4-Lite slave: address and data taken in either order, one write at a time
  logic       aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic       wr_go;

  assign wr_go       = aw_q && w_q && !bv_q;
  assign sw_rsrc_val = wd_q[7:0];
  logic [3:0] ws_q, ws_d;
  assign sw_rsrc_wr  = wr_go && ws_q[0] && (awa_q == RESET_SOURCE_OFF);
  assign sw_lv_wr    = wr_go && ws_q[0] && (awa_q == LV_MODE_OFF);
  assign sw_dbg_wr   = wr_go && ws_q[0] && (awa_q == DEBUG_MODE_OFF);
  assign sw_wd_wr    = wr_go && ws_q[0] && (awa_q == WD_CTRL_OFF);
  assign sw_wd_clr   = sw_wd_wr && wd_q[1];

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == RESET_SOURCE_OFF) || (a == CPU_CLK_STAT_OFF) || (a == LV_MODE_OFF) ||
             (a == DEBUG_MODE_OFF) || (a == WD_CTRL_OFF) || (a == SEQ_STAT_OFF);
  endfunction : mapped

  always_comb
  begin
    aw_d  = aw_q;
    w_d   = w_q;
    awa_d = awa_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    bv_d  = bv_q;
    br_d  = br_q;
    rv_d  = rv_q;
    rr_d  = rr_q;
    rd_d  = rd_q;
    if (s_axi_awvalid && !aw_q)
    begin
      aw_d  = 1'b1;
      awa_d = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !w_q)
    begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_go)
    begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = mapped(awa_q) ? AXI_OKAY : AXI_SLVERR;
    end
    if (bv_q && s_axi_bready)
      bv_d = 1'b0;
    if (s_axi_arvalid && !rv_q)
    begin
      rv_d = 1'b1;
      rr_d = mapped({s_axi_araddr[7:2], 2'b00}) ? AXI_OKAY : AXI_SLVERR;
      unique case ({s_axi_araddr[7:2], 2'b00})
        RESET_SOURCE_OFF: rd_d = {24'h0, rsrc_q};
        CPU_CLK_STAT_OFF: rd_d = {31'h0, out_q[5]};
        LV_MODE_OFF:      rd_d = {30'h0, lvmode_q};
        DEBUG_MODE_OFF:   rd_d = {24'h0, dbg_q};
        WD_CTRL_OFF:      rd_d = {31'h0, wd_rst_en_q};
        SEQ_STAT_OFF:     rd_d = {27'h0, ramc_q, 2'(st_q), lv_below, main_ok};
        default:          rd_d = 32'h0;
      endcase
    end
    else if (rv_q && s_axi_rready)
      rv_d = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0;
      awa_q <= 8'h00; wd_q <= 32'h0; ws_q <= 4'h0; rd_q <= 32'h0;
      br_q <= AXI_OKAY; rr_q <= AXI_OKAY;
    end
    else
    begin
      aw_q <= aw_d; w_q <= w_d; bv_q <= bv_d; rv_q <= rv_d;
      awa_q <= awa_d; wd_q <= wd_d; ws_q <= ws_d; rd_q <= rd_d;
      br_q <= br_d; rr_q <= rr_d;
    end
  end
  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

  // checks
  a_pin_clears_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pin_rst |=> rsrc_q == 8'h00) else $error("pin reset left flags set");
  a_wd_sets_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wd_ovf_ev && !pin_rst |=> rsrc_q[WD_FLAG_BIT]) else $error("watchdog flag not set");
  a_reset_stops_osc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    in_reset |-> !main_osc_en_o && !cpu_clk_en_o && !periph_clk_en_o) else $error("clocks ran in reset");
  a_cpu_after_stab: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(cpu_clk_en_o) |-> $past(stab_done) || cpu_on_int_osc_o) else $error("cpu early");
  a_wd_cnt_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    in_reset |=> wd_cnt_q == 20'h0) else $error("watchdog not cleared");
  a_lv_reset_held: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    lv_hold_q && lv_below |=> in_reset) else $error("low-voltage reset released early");
  a_emerg_int_osc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_q == IRS_STABILIZE) && (wd_cnt_q == 20'(WD_OVF - 1)) && !any_rst |=> cpu_on_int_osc_o)
    else $error("no fall-back to internal oscillator");
endmodule : irs_sequencer
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking testbench for the internal reset sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import irs_pkg::*;
  localparam int HOLD  = 4;
  localparam int SHORT = 16;
  localparam int LONG  = 32;
  localparam int OVF   = 2000;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        pin_n = 1'b1;
  logic        lv_below = 1'b0;
  logic        cm_req = 1'b0;
  logic        long_sel = 1'b0;
  logic        clk_ok = 1'b1;
  logic        ram_acc = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic [2:0]  div;
  wire  [7:0]  mon;
  int          failures = 0;
  int          cmp_count = 0;

  irs_sequencer #(.WD_HOLD(HOLD), .STAB_SHORT(SHORT), .STAB_LONG(LONG), .WD_OVF(OVF)) irs_sequencer_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .pin_reset_n_i(pin_n), .lv_below_i(lv_below),
    .cm_reset_req_i(cm_req), .stab_long_sel_i(long_sel), .main_clk_ok_i(clk_ok), .cpu_ram_access_i(ram_acc),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sys_reset_o(mon[0]), .main_osc_en_o(mon[1]),
    .int_osc_en_o(mon[2]), .cpu_clk_en_o(mon[3]), .periph_clk_en_o(mon[4]), .cpu_div_sel_o(div),
    .cpu_on_int_osc_o(mon[5]), .low_voltage_irq_o(mon[6]), .ram_corrupt_o(mon[7])
  );

  always #2.5 clk_i = ~clk_i;

  task automatic close_out();
    $display("checks %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  // samples on the falling edge so registered outputs have settled
  task automatic wait_bit(input int idx, input logic v, input int lim, output int cyc);
    cyc = 0;
    @(negedge clk_i);
    while (mon[idx] !== v && cyc < lim)
    begin
      @(negedge clk_i);
      cyc++;
    end
    check($sformatf("output %0d level", idx), {31'h0, v}, {31'h0, mon[idx]});
  endtask : wait_bit

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int  n;
    bit  aw;
    bit  w;
    n = 0;
    aw = 1;
    w = 1;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while ((aw || w) && n < 200)
    begin
      @(posedge clk_i);
      n++;
      if (aw && s_axi_awready === 1'b1)
      begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1)
      begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do
    begin
      @(posedge clk_i);
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    check("write answer", 32'h1, {31'h0, s_axi_bvalid});
    s_axi_bready <= 1'b0;
    check("write response", {30'h0, AXI_OKAY}, {30'h0, s_axi_bresp});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (s_axi_arready !== 1'b1 && n < 200);
    s_axi_arvalid <= 1'b0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    check("read answer", 32'h1, {31'h0, s_axi_rvalid});
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check(what, exp, {d[31:8], d[7:0] & ((a == RESET_SOURCE_OFF) ? RESET_SOURCE_MASK : 8'hff)});
  endtask : rd_chk

  // flags after a reset of the given source: 0 pin, 1 clock monitor, 2 low voltage, 3 watchdog
  function automatic logic [7:0] exp_flags(input logic [7:0] old, input int src);
    logic [7:0] f;
    f = old;
    if (src == 0) f = 8'h00;
    if (src == 1) f[CM_FLAG_BIT] = 1'b1;
    if (src == 2) f[LV_FLAG_BIT] = 1'b1;
    if (src == 3) f[WD_FLAG_BIT] = 1'b1;
    return f;
  endfunction : exp_flags

  task automatic in_reset();
    check("clocks during reset", 8'h01, {4'h0, mon[4:1], mon[0]} & 8'h1f);
  endtask : in_reset

  task automatic came_up(input int lim);
    int c;
    wait_bit(0, 1'b0, 200, c);
    wait_bit(3, 1'b1, lim + 40, c);
    check("stabilisation length", 1, c >= lim);
    check("run clocks", {5'h1e, 3'h3}, {mon[4:0], div});
  endtask : came_up

  initial
  begin
    int          c;
    logic [7:0]  flags;
    logic [7:0]  dbg;
    logic [31:0] d;
    logic [1:0]  r;
    bit          acc;
    void'($urandom(32'ha0756b7c));
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    came_up(SHORT);
    axi_rd(8'h1c, d, r);
    check("unmapped response", {30'h0, AXI_SLVERR}, {30'h0, r});
    check("unmapped data", 32'h0, d);
    rd_chk("cpu clock status", CPU_CLK_STAT_OFF, 32'h0);
    // pin reset clears every flag and presets the debug register, even against a monitor request
    axi_wr(DEBUG_MODE_OFF, 32'h0);
    @(posedge clk_i);
    pin_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    cm_req <= 1'b1;
    @(posedge clk_i);
    cm_req <= 1'b0;
    wait_bit(0, 1'b1, 20, c);
    in_reset();
    @(posedge clk_i);
    pin_n <= 1'b1;
    came_up(SHORT);
    rd_chk("flags after pin reset", RESET_SOURCE_OFF, 32'h0);
    rd_chk("debug after pin reset", DEBUG_MODE_OFF, {24'h0, DEBUG_MODE_RST});
    flags = 8'h00;
    for (int src = 1; src <= 3; src++)
    begin
      dbg = 8'($urandom);
      axi_wr(DEBUG_MODE_OFF, {24'h0, dbg});
      @(posedge clk_i);
      long_sel <= (src == 2);
      acc = (src != 2) && ($urandom % 2 == 1);
      ram_acc <= acc;
      if (src == 1)
      begin
        cm_req <= 1'b1;
        @(posedge clk_i);
        cm_req <= 1'b0;
        wait_bit(0, 1'b1, 20, c);
      end
      if (src == 2)
      begin
        axi_wr(LV_MODE_OFF, 32'h3);
        @(posedge clk_i);
        lv_below <= 1'b1;
        wait_bit(0, 1'b1, 20, c);
        repeat (20 + $urandom % 20) @(posedge clk_i);
        @(negedge clk_i);
        check("reset held while supply low", 1, mon[0]);
        in_reset();
        @(posedge clk_i);
        lv_below <= 1'b0;
      end
      if (src == 3)
      begin
        axi_wr(WD_CTRL_OFF, 32'h3);
        wait_bit(0, 1'b1, OVF + 20, c);
        check("watchdog period", 1, c >= OVF - 10 && c <= OVF + 10);
      end
      if (src != 2) in_reset();
      if (src == 3)
      begin
        repeat (HOLD) @(negedge clk_i);
        check("reset held for the hold time", 1, mon[0]);
      end
      @(posedge clk_i);
      ram_acc <= 1'b0;
      came_up((src == 2) ? LONG : SHORT);
      check("ram damage flag", {31'h0, acc || (src == 2)}, {31'h0, mon[7]});
      flags = exp_flags(flags, src);
      rd_chk("flags after reset", RESET_SOURCE_OFF, {24'h0, flags});
      rd_chk("debug kept", DEBUG_MODE_OFF, {24'h0, dbg});
    end
    axi_wr(RESET_SOURCE_OFF, 32'hff);
    rd_chk("flags after writing ones", RESET_SOURCE_OFF, {24'h0, flags});
    axi_wr(RESET_SOURCE_OFF, 32'h0);
    rd_chk("flags after clear", RESET_SOURCE_OFF, 32'h0);
    // interrupt mode: both crossings pulse, no reset
    axi_wr(LV_MODE_OFF, 32'h1);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_i);
      lv_below <= (k == 0);
      wait_bit(6, 1'b1, 10, c);
      check("no reset in interrupt mode", 0, mon[0]);
    end
    // two sources in the same cycle
    axi_wr(LV_MODE_OFF, 32'h3);
    // the detector input passes two sync flops, so it leads the monitor request by two edges
    @(posedge clk_i);
    lv_below <= 1'b1;
    repeat (2) @(posedge clk_i);
    cm_req <= 1'b1;
    @(posedge clk_i);
    cm_req <= 1'b0;
    repeat (10) @(posedge clk_i);
    lv_below <= 1'b0;
    came_up(SHORT);
    rd_chk("flags after joint reset", RESET_SOURCE_OFF, 32'h3);
    // main clock dead: watchdog overflow during stabilisation falls back to internal oscillator
    @(posedge clk_i);
    clk_ok <= 1'b0;
    cm_req <= 1'b1;
    @(posedge clk_i);
    cm_req <= 1'b0;
    wait_bit(0, 1'b1, 20, c);
    wait_bit(0, 1'b0, 200, c);
    axi_wr(WD_CTRL_OFF, 32'h0);
    wait_bit(5, 1'b1, OVF + 50, c);
    check("emergency clocks", 2'b01, {mon[4], mon[3]});
    // only the status register is touched while on the internal oscillator
    rd_chk("cpu clock status emergency", CPU_CLK_STAT_OFF, 32'h1);
    close_out();
  end

  initial
  begin
    repeat (60000) @(posedge clk_i);
    failures++;
    $display("unexpected run length: expected end before 60000 cycles, seen timeout");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
